// *** pkg/host_port_pkg.sv ***
// Shared constants, modes and state codes for the host control port.
// Assumes one 250 MHz clock on both ends and the pins of host_port_if.
package host_port_pkg;

  // ----------------------------------------------------------------
  // Widths and modes
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int PIN_ADDR_W = 5;
  localparam int NCH = 8;

  typedef enum logic [1:0] {
    MODE_HW = 2'h0,
    MODE_DS = 2'h1,
    MODE_ALE = 2'h2,
    MODE_SERIAL = 2'h3
  } bus_mode_e;

  // ----------------------------------------------------------------
  // Device registers on the pin bus
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_AIS_STAT = 8'h00;
  localparam logic [7:0] REG_LOS_STAT = 8'h01;
  localparam logic [7:0] REG_AIS_EN = 8'h02;
  localparam logic [7:0] REG_LOS_EN = 8'h03;
  localparam logic [7:0] REG_AIS_CHG = 8'h04;
  localparam logic [7:0] REG_LOS_CHG = 8'h05;
  localparam logic [7:0] EN_RST = 8'h00;

  // ----------------------------------------------------------------
  // Controller registers on AXI4-Lite
  // ----------------------------------------------------------------
  localparam logic [7:0] AX_CTRL = 8'h00;
  localparam logic [7:0] AX_ADDR = 8'h04;
  localparam logic [7:0] AX_WDATA = 8'h08;
  localparam logic [7:0] AX_RDATA = 8'h0c;
  localparam logic [7:0] AX_INT_STAT = 8'h10;
  localparam logic [7:0] AX_INT_MASK = 8'h14;
  localparam int CTRL_GO = 0;
  localparam int CTRL_READ = 1;
  localparam int CTRL_MODE = 2;
  localparam int INT_DONE = 0;
  localparam int INT_DEV = 1;
  localparam int RDATA_BUSY = 8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int PHASE_NS = 16;
  localparam int PHASE_CYC = (PHASE_NS * 1000 + CLK_PERIOD_PS - 1)
                             / CLK_PERIOD_PS;
  localparam logic [3:0] PHASE_LAST = 4'(PHASE_CYC - 1);

  // ----------------------------------------------------------------
  // State codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DEV_IDLE = 2'b00,
    DEV_ACT = 2'b01,
    DEV_DONE = 2'b11
  } dev_state_e;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_SETUP = 3'b001,
    H_LATCH = 3'b011,
    H_STROBE = 3'b010,
    H_WAIT = 3'b110,
    H_END = 3'b111
  } host_state_e;

endpackage

// *** pkg/host_port_if.sv ***
// Pins between the controller and the transceiver's host port.
// Resolves the shared wires: data and ack pull up, ready pulls down,
// the open-drain interrupt line pulls up.
`timescale 1ns/1ps
interface host_port_if;
  logic csN;
  logic dsN;
  logic rwN;
  logic ale;
  logic [4:0] addr;
  logic [7:0] hostData;
  logic hostDataOe;
  logic [7:0] devData;
  logic devDataOe;
  logic ackOut;
  logic ackOe;
  logic rdyOut;
  logic rdyOe;
  logic irqOut;
  logic irqOe;
  logic [7:0] dataBus;
  logic ackN;
  logic rdy;
  logic irqN;

  assign dataBus = devDataOe ? devData : (hostDataOe ? hostData : 8'hff);
  assign ackN = ackOe ? ackOut : 1'b1;
  assign rdy = rdyOe ? rdyOut : 1'b0;
  assign irqN = (irqOe && !irqOut) ? 1'b0 : 1'b1;

  modport dev (
    input csN, dsN, rwN, ale, addr, dataBus,
    output devData, devDataOe, ackOut, ackOe, rdyOut, rdyOe, irqOut, irqOe
  );
  modport host (
    input dataBus, ackN, rdy, irqN,
    output csN, dsN, rwN, ale, addr, hostData, hostDataOe
  );
endinterface

// *** hdl/host_port_dev.sv ***
// Transceiver end of the host control port: pin decode, registers,
// alarm change flags and the open-drain interrupt.
// Assumes all pins arrive asynchronously and the mode strap is static.
`timescale 1ns/1ps

// Contract
// - Accesses accepted only while chip select low
// - Hardware mode: select pin picks jitter path
// - Non-multiplexed: bus is bidirectional data port
// - Multiplexed: bus carries address then data
// - Serial mode: bus grounded and ignored
// - Hardware mode: bus bits are loopback controls
// - Data strobe qualifies each transfer (code: multiplexed reads strobe on rwN low, data strobe stays high)
// - Hardware mode: board grounds data strobe
// - Interrupt is open drain, only pulls low
// - Enabled alarm status change pulls interrupt low
// - Address latched on falling latch enable
// - Ack low: read data valid, write taken
// - Ready low busy, high done, then released
// - Host treats interrupt as a level
module host_port_dev (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Pin side
  host_port_if.dev pins,
  // Mode strap
  input wire host_port_pkg::bus_mode_e modeStrap,
  // Line alarm status per channel
  input wire logic [7:0] allOnesAlarm,
  input wire logic [7:0] inputSignalAbsent,
  // Hardware mode controls
  output logic jitterAttenPathSel,
  output logic [7:0] perChannelLoopbackCtl
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int SYNC_W = 35;
  logic [SYNC_W-1:0] syncIn;
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;

  assign syncIn = {pins.csN, pins.dsN, pins.rwN, pins.ale, pins.addr,
                   pins.dataBus, allOnesAlarm, inputSignalAbsent, modeStrap};

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= syncIn;
      sync2_r <= sync1_r;
    end
  end

  logic csS;
  logic dsS;
  logic rwS;
  logic aleS;
  logic [4:0] addrS;
  logic [7:0] dataS;
  logic [7:0] aisS;
  logic [7:0] losS;
  host_port_pkg::bus_mode_e modeS;

  assign csS = sync2_r[34];
  assign dsS = sync2_r[33];
  assign rwS = sync2_r[32];
  assign aleS = sync2_r[31];
  assign addrS = sync2_r[30:26];
  assign dataS = sync2_r[25:18];
  assign aisS = sync2_r[17:10];
  assign losS = sync2_r[9:2];
  assign modeS = host_port_pkg::bus_mode_e'(sync2_r[1:0]);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic parMode;
  logic sel;
  logic strobe;
  logic isRead;
  logic [7:0] accAddr;

  assign parMode = (modeS == host_port_pkg::MODE_DS) ||
                   (modeS == host_port_pkg::MODE_ALE);
  assign sel = parMode && !csS;
  always_comb begin
    if (modeS == host_port_pkg::MODE_ALE) begin
      strobe = !dsS || !rwS;
      isRead = !rwS;
    end else begin
      strobe = !dsS;
      isRead = rwS;
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  host_port_pkg::dev_state_e state_r;
  host_port_pkg::dev_state_e state_nxt;
  logic aleD_r;
  logic aleD_nxt;
  logic [7:0] latAddr_r;
  logic [7:0] latAddr_nxt;
  logic [7:0] rdData_r;
  logic [7:0] rdData_nxt;
  logic drive_r;
  logic drive_nxt;
  logic [7:0] aisEn_r;
  logic [7:0] aisEn_nxt;
  logic [7:0] losEn_r;
  logic [7:0] losEn_nxt;
  logic [7:0] aisChg_r;
  logic [7:0] aisChg_nxt;
  logic [7:0] losChg_r;
  logic [7:0] losChg_nxt;
  logic [7:0] aisPrev_r;
  logic [7:0] losPrev_r;
  logic irq_r;
  logic irq_nxt;
  logic jSel_r;
  logic jSel_nxt;
  logic [7:0] loop_r;
  logic [7:0] loop_nxt;

  assign accAddr = (modeS == host_port_pkg::MODE_ALE) ? latAddr_r
                                                       : {3'h0, addrS};

  always_comb begin
    logic [7:0] aisClr;
    logic [7:0] losClr;
    aisClr = 8'h00;
    losClr = 8'h00;
    state_nxt = state_r;
    aleD_nxt = aleS;
    latAddr_nxt = latAddr_r;
    rdData_nxt = rdData_r;
    drive_nxt = drive_r;
    aisEn_nxt = aisEn_r;
    losEn_nxt = losEn_r;
    if (modeS == host_port_pkg::MODE_ALE && sel && aleD_r && !aleS) begin
      latAddr_nxt = dataS;
    end
    unique case (state_r)
      host_port_pkg::DEV_IDLE: begin
        drive_nxt = 1'b0;
        if (sel && strobe) begin
          state_nxt = host_port_pkg::DEV_ACT;
        end
      end
      host_port_pkg::DEV_ACT: begin
        state_nxt = host_port_pkg::DEV_DONE;
        if (isRead) begin
          drive_nxt = 1'b1;
          unique case (accAddr)
            host_port_pkg::REG_AIS_STAT: rdData_nxt = aisS;
            host_port_pkg::REG_LOS_STAT: rdData_nxt = losS;
            host_port_pkg::REG_AIS_EN: rdData_nxt = aisEn_r;
            host_port_pkg::REG_LOS_EN: rdData_nxt = losEn_r;
            host_port_pkg::REG_AIS_CHG: rdData_nxt = aisChg_r;
            host_port_pkg::REG_LOS_CHG: rdData_nxt = losChg_r;
            default: rdData_nxt = 8'h00;
          endcase
        end else begin
          unique case (accAddr)
            host_port_pkg::REG_AIS_EN: aisEn_nxt = dataS;
            host_port_pkg::REG_LOS_EN: losEn_nxt = dataS;
            host_port_pkg::REG_AIS_CHG: aisClr = dataS;
            host_port_pkg::REG_LOS_CHG: losClr = dataS;
            default: begin
            end
          endcase
        end
      end
      host_port_pkg::DEV_DONE: begin
        if (!(sel && strobe)) begin
          state_nxt = host_port_pkg::DEV_IDLE;
          drive_nxt = 1'b0;
        end
      end
      default: begin
        state_nxt = host_port_pkg::DEV_IDLE;
        drive_nxt = 1'b0;
      end
    endcase
    if (!sel) begin
      state_nxt = host_port_pkg::DEV_IDLE;
      drive_nxt = 1'b0;
    end
    aisChg_nxt = (aisChg_r & ~aisClr) | (aisS ^ aisPrev_r);
    losChg_nxt = (losChg_r & ~losClr) | (losS ^ losPrev_r);
    irq_nxt = |(aisChg_r & aisEn_r) || |(losChg_r & losEn_r);
    jSel_nxt = (modeS == host_port_pkg::MODE_HW) ? csS : 1'b0;
    loop_nxt = (modeS == host_port_pkg::MODE_HW) ? dataS : 8'h00;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r <= host_port_pkg::DEV_IDLE;
      aleD_r <= 1'b0;
      latAddr_r <= 8'h00;
      rdData_r <= 8'h00;
      drive_r <= 1'b0;
      aisEn_r <= host_port_pkg::EN_RST;
      losEn_r <= host_port_pkg::EN_RST;
      aisChg_r <= 8'h00;
      losChg_r <= 8'h00;
      aisPrev_r <= 8'h00;
      losPrev_r <= 8'h00;
      irq_r <= 1'b0;
      jSel_r <= 1'b0;
      loop_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      aleD_r <= aleD_nxt;
      latAddr_r <= latAddr_nxt;
      rdData_r <= rdData_nxt;
      drive_r <= drive_nxt;
      aisEn_r <= aisEn_nxt;
      losEn_r <= losEn_nxt;
      aisChg_r <= aisChg_nxt;
      losChg_r <= losChg_nxt;
      aisPrev_r <= aisS;
      losPrev_r <= losS;
      irq_r <= irq_nxt;
      jSel_r <= jSel_nxt;
      loop_r <= loop_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  assign pins.devData = rdData_r;
  assign pins.devDataOe = drive_r && sel;
  assign pins.ackOe = sel && (modeS == host_port_pkg::MODE_DS);
  assign pins.ackOut = (state_r != host_port_pkg::DEV_DONE);
  assign pins.rdyOe = sel && (modeS == host_port_pkg::MODE_ALE) &&
                      (state_r != host_port_pkg::DEV_IDLE);
  assign pins.rdyOut = (state_r == host_port_pkg::DEV_DONE);
  assign pins.irqOut = 1'b0;
  assign pins.irqOe = irq_r;
  assign jitterAttenPathSel = jSel_r;
  assign perChannelLoopbackCtl = loop_r;

endmodule // host_port_dev

// *** hdl/host_port_ctl.sv ***
// Controller end of the host control port, steered over AXI4-Lite.
// Assumes pin answers arrive asynchronously; one access at a time.
`timescale 1ns/1ps
module host_port_ctl (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // AXI4-Lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Interrupt
  output logic irq,
  // Pin side
  host_port_if.host pins
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [10:0] s1_r;
  logic [10:0] s2_r;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= 11'h5ff;
      s2_r <= 11'h5ff;
    end else begin
      s1_r <= {pins.ackN, pins.rdy, pins.irqN, pins.dataBus};
      s2_r <= s1_r;
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  host_port_pkg::host_state_e st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] aw_r, aw_nxt;
  logic awHave_r, awHave_nxt, wHave_r, wHave_nxt;
  logic [31:0] wd_r, wd_nxt;
  logic bv_r, bv_nxt, rv_r, rv_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic rdOp_r, rdOp_nxt;
  logic [1:0] mode_r, mode_nxt;
  logic [7:0] tAddr_r, tAddr_nxt, tData_r, tData_nxt, res_r, res_nxt;
  logic [1:0] ist_r, ist_nxt, imask_r, imask_nxt;
  logic csN_r, csN_nxt, dsN_r, dsN_nxt, rwN_r, rwN_nxt, ale_r, ale_nxt;
  logic [7:0] hd_r, hd_nxt;
  logic hoe_r, hoe_nxt;
  logic tick, isAle, answered, doWr, busy;

  assign tick = (cnt_r == host_port_pkg::PHASE_LAST);
  assign isAle = (mode_r == host_port_pkg::MODE_ALE);
  assign answered = isAle ? s2_r[9] : !s2_r[10];
  assign doWr = awHave_r && wHave_r && !bv_r;
  assign busy = (st_r != host_port_pkg::H_IDLE);

  always_comb begin
    logic [1:0] iset;
    logic [1:0] iclr;
    iset = {!s2_r[8], 1'b0};
    iclr = 2'h0;
    st_nxt = st_r;
    cnt_nxt = tick ? 4'h0 : cnt_r + 4'h1;
    aw_nxt = aw_r;
    awHave_nxt = awHave_r || (awvalid && !awHave_r);
    wHave_nxt = wHave_r || (wvalid && !wHave_r);
    wd_nxt = wd_r;
    bv_nxt = bv_r && !bready;
    rv_nxt = rv_r && !rready;
    rd_nxt = rd_r;
    rdOp_nxt = rdOp_r;
    mode_nxt = mode_r;
    tAddr_nxt = tAddr_r;
    tData_nxt = tData_r;
    res_nxt = res_r;
    imask_nxt = imask_r;
    csN_nxt = csN_r;
    dsN_nxt = dsN_r;
    rwN_nxt = rwN_r;
    ale_nxt = ale_r;
    hd_nxt = hd_r;
    hoe_nxt = hoe_r;
    if (awvalid && !awHave_r) aw_nxt = awaddr;
    if (wvalid && !wHave_r) wd_nxt = wdata;
    if (doWr) begin
      awHave_nxt = 1'b0;
      wHave_nxt = 1'b0;
      bv_nxt = 1'b1;
      unique case (aw_r)
        host_port_pkg::AX_CTRL: if (!busy && wstrb[0]) begin
          rdOp_nxt = wd_r[host_port_pkg::CTRL_READ];
          mode_nxt = wd_r[host_port_pkg::CTRL_MODE +: 2];
          if (wd_r[host_port_pkg::CTRL_GO]) begin
            st_nxt = host_port_pkg::H_SETUP;
            cnt_nxt = 4'h0;
          end
        end
        host_port_pkg::AX_ADDR: if (wstrb[0]) tAddr_nxt = wd_r[7:0];
        host_port_pkg::AX_WDATA: if (wstrb[0]) tData_nxt = wd_r[7:0];
        host_port_pkg::AX_INT_STAT: if (wstrb[0]) iclr = wd_r[1:0];
        host_port_pkg::AX_INT_MASK: if (wstrb[0]) imask_nxt = wd_r[1:0];
        default: begin
        end
      endcase
    end
    if (arvalid && !rv_r) begin
      rv_nxt = 1'b1;
      unique case (araddr)
        host_port_pkg::AX_CTRL: rd_nxt = {28'h0, mode_r, rdOp_r, busy};
        host_port_pkg::AX_ADDR: rd_nxt = {24'h0, tAddr_r};
        host_port_pkg::AX_WDATA: rd_nxt = {24'h0, tData_r};
        host_port_pkg::AX_RDATA: rd_nxt = {23'h0, busy, res_r};
        host_port_pkg::AX_INT_STAT: rd_nxt = {30'h0, ist_r};
        host_port_pkg::AX_INT_MASK: rd_nxt = {30'h0, imask_r};
        default: rd_nxt = 32'h0;
      endcase
    end
    unique case (st_r)
      host_port_pkg::H_IDLE: begin
        csN_nxt = 1'b1;
        dsN_nxt = (mode_r != host_port_pkg::MODE_HW);
        rwN_nxt = 1'b1;
        ale_nxt = 1'b0;
        hoe_nxt = 1'b0;
      end
      host_port_pkg::H_SETUP: begin
        csN_nxt = 1'b0;
        rwN_nxt = isAle ? 1'b1 : rdOp_r;
        ale_nxt = isAle;
        hd_nxt = isAle ? tAddr_r : tData_r;
        hoe_nxt = isAle || !rdOp_r;
        if (tick) st_nxt = isAle ? host_port_pkg::H_LATCH
                                 : host_port_pkg::H_STROBE;
      end
      host_port_pkg::H_LATCH: begin
        ale_nxt = 1'b0;
        if (tick) st_nxt = host_port_pkg::H_STROBE;
      end
      host_port_pkg::H_STROBE: begin
        hd_nxt = tData_r;
        hoe_nxt = !rdOp_r;
        dsN_nxt = isAle ? rdOp_r : 1'b0;
        rwN_nxt = isAle ? !rdOp_r : rdOp_r;
        st_nxt = host_port_pkg::H_WAIT;
      end
      host_port_pkg::H_WAIT: if (answered) begin
        res_nxt = s2_r[7:0];
        dsN_nxt = 1'b1;
        rwN_nxt = 1'b1;
        cnt_nxt = 4'h0;
        st_nxt = host_port_pkg::H_END;
      end
      host_port_pkg::H_END: begin
        csN_nxt = 1'b1;
        hoe_nxt = 1'b0;
        if (tick) begin
          st_nxt = host_port_pkg::H_IDLE;
          iset[host_port_pkg::INT_DONE] = 1'b1;
        end
      end
      default: st_nxt = host_port_pkg::H_IDLE;
    endcase
    ist_nxt = (ist_r & ~iclr) | iset;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_r <= host_port_pkg::H_IDLE;
      cnt_r <= 4'h0;
      aw_r <= 8'h00;
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
      wd_r <= 32'h0;
      bv_r <= 1'b0;
      rv_r <= 1'b0;
      rd_r <= 32'h0;
      rdOp_r <= 1'b0;
      mode_r <= 2'h1;
      tAddr_r <= 8'h00;
      tData_r <= 8'h00;
      res_r <= 8'h00;
      ist_r <= 2'h0;
      imask_r <= 2'h0;
      csN_r <= 1'b1;
      dsN_r <= 1'b1;
      rwN_r <= 1'b1;
      ale_r <= 1'b0;
      hd_r <= 8'h00;
      hoe_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      aw_r <= aw_nxt;
      awHave_r <= awHave_nxt;
      wHave_r <= wHave_nxt;
      wd_r <= wd_nxt;
      bv_r <= bv_nxt;
      rv_r <= rv_nxt;
      rd_r <= rd_nxt;
      rdOp_r <= rdOp_nxt;
      mode_r <= mode_nxt;
      tAddr_r <= tAddr_nxt;
      tData_r <= tData_nxt;
      res_r <= res_nxt;
      ist_r <= ist_nxt;
      imask_r <= imask_nxt;
      csN_r <= csN_nxt;
      dsN_r <= dsN_nxt;
      rwN_r <= rwN_nxt;
      ale_r <= ale_nxt;
      hd_r <= hd_nxt;
      hoe_r <= hoe_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign awready = !awHave_r;
  assign wready = !wHave_r;
  assign bvalid = bv_r;
  assign bresp = 2'h0;
  assign arready = !rv_r;
  assign rvalid = rv_r;
  assign rdata = rd_r;
  assign rresp = 2'h0;
  assign irq = |(ist_r & imask_r);
  assign pins.csN = csN_r;
  assign pins.dsN = dsN_r;
  assign pins.rwN = rwN_r;
  assign pins.ale = ale_r;
  assign pins.addr = tAddr_r[4:0];
  assign pins.hostData = hd_r;
  assign pins.hostDataOe = hoe_r;

endmodule // host_port_ctl

// *** verification/host_port_checker.sv ***
// Concurrent checks on the host port pins.
// Assumes it sits beside host_port_if in the bench top.
`timescale 1ns/1ps
module host_port_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Host driven pins
  input wire logic csN,
  input wire logic dsN,
  input wire logic hostDataOe,
  // Device driven pins
  input wire logic devDataOe,
  input wire logic ackOe,
  input wire logic ackN,
  input wire logic rdy,
  input wire logic rdyOe,
  input wire logic rdyOut,
  input wire logic irqOe,
  input wire logic irqOut
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence deselS;
    csN [*5];
  endsequence
  sequence strobeEndS;
    $rose(dsN);
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_irq_open_drain: assert property (irqOe |-> !irqOut)
    else $error("Interrupt line driven high");
  a_desel_bus_off: assert property (deselS |-> !devDataOe)
    else $error("Data bus driven while deselected");
  a_desel_no_answer: assert property (deselS |-> !ackOe && !rdyOe)
    else $error("Answer driven while deselected");
  a_no_bus_clash: assert property (!(devDataOe && hostDataOe))
    else $error("Both ends drive the data bus");
  a_ack_in_strobe: assert property ($fell(ackN) |-> !dsN && !csN)
    else $error("Acknowledge outside a strobe");
  a_ack_release: assert property (strobeEndS |-> ##[0:5] ackN)
    else $error("Acknowledge held after strobe end");
  a_rdy_busy_first: assert property ($rose(rdyOe) |-> !rdyOut)
    else $error("Ready not low at start of transfer");
  a_rdy_tristate: assert property ($rose(rdy) |-> ##[1:16] !rdyOe)
    else $error("Ready not released after completion");
  a_rdy_selected: assert property ($rose(rdy) |-> !csN)
    else $error("Ready raised while deselected");
endmodule // host_port_checker

// *** verification/test_host_bus_pin_function_select.sv ***
// Bench for both ends of the host port, driven over AXI4-Lite.
// Assumes the package, interface and both design modules are compiled.
`timescale 1ns/1ps
module test_host_bus_pin_function_select;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, jitterAttenPathSel;
  logic [1:0] bresp, rresp;
  logic [7:0] allOnesAlarm = 8'h00, inputSignalAbsent = 8'h00;
  logic [7:0] perChannelLoopbackCtl;
  host_port_pkg::bus_mode_e modeStrap = host_port_pkg::MODE_DS;
  host_port_pkg::bus_mode_e md;
  int errCount = 0, samplesChecked = 0;

  always #2 mclk = ~mclk;

  host_port_if host_port_if_inst ();
  host_port_dev host_port_dev_inst (.mclk(mclk), .nrst(nrst),
    .pins(host_port_if_inst), .modeStrap(modeStrap),
    .allOnesAlarm(allOnesAlarm), .inputSignalAbsent(inputSignalAbsent),
    .jitterAttenPathSel(jitterAttenPathSel),
    .perChannelLoopbackCtl(perChannelLoopbackCtl));
  host_port_ctl host_port_ctl_inst (.mclk(mclk), .nrst(nrst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .irq(irq), .pins(host_port_if_inst));
  host_port_checker host_port_checker_inst (.mclk(mclk), .nrst(nrst),
    .csN(host_port_if_inst.csN), .dsN(host_port_if_inst.dsN),
    .hostDataOe(host_port_if_inst.hostDataOe),
    .devDataOe(host_port_if_inst.devDataOe),
    .ackOe(host_port_if_inst.ackOe), .ackN(host_port_if_inst.ackN),
    .rdy(host_port_if_inst.rdy), .rdyOe(host_port_if_inst.rdyOe),
    .rdyOut(host_port_if_inst.rdyOut), .irqOe(host_port_if_inst.irqOe),
    .irqOut(host_port_if_inst.irqOut));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic endSim();
    $display("Checks %0d, mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tmo(input int n);
    if (n >= 200) begin
      check(32'h0, 32'h1);
      endSim();
    end
  endtask

  task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 200);
    tmo(n);
    check({30'h0, bresp}, 32'h0);
    bready <= 1'b0;
  endtask

  task automatic axiRd(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 200);
    tmo(n);
    check({30'h0, rresp}, 32'h0);
    d = rdata;
    rready <= 1'b0;
  endtask

  // One pin bus access through the controller, polling its busy bit
  task automatic pinAcc(input logic [1:0] m, input logic rd,
                        input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    logic [31:0] r;
    int n;
    axiWr(host_port_pkg::AX_ADDR, {24'h0, a});
    axiWr(host_port_pkg::AX_WDATA, {24'h0, d});
    axiWr(host_port_pkg::AX_CTRL, {28'h0, m, rd, 1'b1});
    r = 32'h100;
    n = 0;
    while (r[8] !== 1'b0 && n < 200) begin
      axiRd(host_port_pkg::AX_RDATA, r);
      n++;
    end
    tmo(n);
    q = r[7:0];
  endtask

  task automatic devChk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    pinAcc(md, 1'b1, a, 8'h00, q);
    check({24'h0, q}, {24'h0, e});
  endtask

  task automatic devWr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    pinAcc(md, 1'b0, a, d, q);
  endtask

  // ----------------------------------------------------------------
  // Sequence of tests
  // ----------------------------------------------------------------
  initial begin
    md = host_port_pkg::MODE_DS;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    axiRd(host_port_pkg::AX_INT_MASK, v);
    check(v, 32'h0);
    axiRd(host_port_pkg::AX_INT_STAT, v);
    check(v, 32'h0);
    axiRd(8'h20, v);
    check(v, 32'h0);
    check({31'h0, irq}, 32'h0);
    check({31'h0, jitterAttenPathSel}, 32'h0);
    devChk(host_port_pkg::REG_AIS_EN, host_port_pkg::EN_RST);
    $display("Test reset values done");
    for (int i = 0; i < 2; i++) begin
      md = i ? host_port_pkg::MODE_ALE : host_port_pkg::MODE_DS;
      modeStrap <= md;
      repeat (4) @(posedge mclk);
      devWr(host_port_pkg::REG_AIS_EN, 8'ha5 ^ 8'(i));
      devWr(host_port_pkg::REG_LOS_EN, 8'h3c ^ 8'(i));
      devChk(host_port_pkg::REG_AIS_EN, 8'ha5 ^ 8'(i));
      devChk(host_port_pkg::REG_LOS_EN, 8'h3c ^ 8'(i));
    end
    $display("Test data strobe and latch enable buses done");
    md = host_port_pkg::MODE_DS;
    modeStrap <= md;
    repeat (4) @(posedge mclk);
    devWr(host_port_pkg::REG_AIS_EN, 8'h01);
    devWr(host_port_pkg::REG_LOS_EN, 8'h00);
    axiWr(host_port_pkg::AX_INT_MASK, 32'h2);
    axiWr(host_port_pkg::AX_INT_STAT, 32'h3);
    allOnesAlarm <= 8'h02;
    repeat (10) @(posedge mclk);
    check({31'h0, host_port_if_inst.irqN}, 32'h1);
    allOnesAlarm <= 8'h03;
    repeat (10) @(posedge mclk);
    check({31'h0, host_port_if_inst.irqN}, 32'h0);
    check({31'h0, irq}, 32'h1);
    axiWr(host_port_pkg::AX_INT_MASK, 32'h0);
    repeat (2) @(posedge mclk);
    check({31'h0, irq}, 32'h0);
    axiWr(host_port_pkg::AX_INT_MASK, 32'h2);
    devChk(host_port_pkg::REG_AIS_CHG, 8'h03);
    devChk(host_port_pkg::REG_AIS_STAT, 8'h03);
    devWr(host_port_pkg::REG_AIS_CHG, 8'h03);
    repeat (4) @(posedge mclk);
    check({31'h0, host_port_if_inst.irqN}, 32'h1);
    axiWr(host_port_pkg::AX_INT_STAT, 32'h2);
    repeat (2) @(posedge mclk);
    check({31'h0, irq}, 32'h0);
    $display("Test interrupt done");
    modeStrap <= host_port_pkg::MODE_HW;
    axiWr(host_port_pkg::AX_CTRL, 32'h0);
    repeat (8) @(posedge mclk);
    check({31'h0, jitterAttenPathSel}, 32'h1);
    check({24'h0, perChannelLoopbackCtl}, 32'hff);
    check({31'h0, host_port_if_inst.dsN}, 32'h0);
    modeStrap <= host_port_pkg::MODE_SERIAL;
    repeat (8) @(posedge mclk);
    check({24'h0, perChannelLoopbackCtl}, 32'h0);
    $display("Test hardware and serial modes done");
    endSim();
  end
endmodule // test_host_bus_pin_function_select
